// ==== hdl/pbs_defs.vh ====
// pbs_defs.vh: shared constants of the pipelined burst memory core.
// assumes: included by bare name from every design file that needs it.
`ifndef PBS_DEFS_VH
`define PBS_DEFS_VH

`define PBS_ADDR_W 16
`define PBS_DATA_W 32
`define PBS_LANES 4
`define PBS_LANE_W 8
`define PBS_BURST_W 2
`define PBS_WAKE_CYCLES 2
`define PBS_WAKE_W 2
`define PBS_WAKE_ZERO 2'h0
`define PBS_WAKE_ONE 2'h1
`define PBS_CNT_ZERO 2'h0
`define PBS_CNT_ONE 2'h1
`define PBS_ADDR_ZERO 16'h0000
`define PBS_DATA_ZERO 32'h00000000
`define PBS_LANES_NONE 4'h0
`define PBS_LANES_ALL 4'hF
`define PBS_ORDER_LINEAR 1'b0
`define PBS_ORDER_INTERLEAVED 1'b1

`endif

// ==== hdl/pbs_mem.v ====
// pbs_mem.v: word array with byte-lane writes and a registered read port.
// assumes: one clock; the caller gates clk_en; no reset of the contents.
`timescale 1ns/10ps
`include "pbs_defs.vh"

module pbs_mem #(
   parameter ADDR_W = `PBS_ADDR_W,
   parameter LANES = `PBS_LANES,
   parameter LANE_W = `PBS_LANE_W
) (
   input wire clock,
   input wire clk_en,
   input wire [ADDR_W-1:0] rd_addr,
   output reg [LANES*LANE_W-1:0] rd_data_q,
   input wire [LANES-1:0] wr_lanes,
   input wire [ADDR_W-1:0] wr_addr,
   input wire [LANES*LANE_W-1:0] wr_data
);

   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1)
      begin : lane
         reg [LANE_W-1:0] cells [0:(1<<ADDR_W)-1];
         always @(posedge clock)
         begin
            if (clk_en)
            begin
               if (wr_lanes[g])
               begin
                  cells[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
               end
               // old contents on a same-address write; no bypass
               rd_data_q[g*LANE_W +: LANE_W] <= cells[rd_addr];
            end
         end
      end
   endgenerate

endmodule // pbs_mem

// ==== hdl/pbs_burst.v ====
// pbs_burst.v: burst address register with 2-bit beat counter.
// assumes: load and advance come from the core on the same clock.
`timescale 1ns/10ps
`include "pbs_defs.vh"

module pbs_burst #(
   parameter ADDR_W = `PBS_ADDR_W,
   parameter BURST_W = `PBS_BURST_W
) (
   input wire clock,
   input wire sys_rst,
   input wire clk_en,
   input wire load,
   input wire advance,
   input wire [ADDR_W-1:0] ext_addr,
   input wire order,
   output wire [ADDR_W-1:0] cur_addr
);

   reg [ADDR_W-1:0] base_q;
   reg [BURST_W-1:0] count_q;
   wire [BURST_W-1:0] start_bits;
   wire [BURST_W-1:0] beat_bits;

   always @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         base_q <= `PBS_ADDR_ZERO;
         count_q <= `PBS_CNT_ZERO;
      end
      else if (clk_en)
      begin
         if (load)
         begin
            base_q <= ext_addr;
            count_q <= `PBS_CNT_ZERO;
         end
         else if (advance)
         begin
            // counter width alone gives the wrap after four beats
            count_q <= count_q + `PBS_CNT_ONE;
         end
      end
   end

   assign start_bits = base_q[BURST_W-1:0];
   assign beat_bits = (order == `PBS_ORDER_INTERLEAVED) ? (start_bits ^ count_q) : (start_bits + count_q);
   assign cur_addr = {base_q[ADDR_W-1:BURST_W], beat_bits};

endmodule // pbs_burst

// ==== hdl/pbs_core.v ====
// pbs_core.v: pipelined burst static memory core, one clock, pin-level ports.
// assumes: host logic drives the synchronous inputs on this clock;
// output drive enable, order select and power-down are asynchronous.
`timescale 1ns/10ps
`include "pbs_defs.vh"

module pbs_core #(
   parameter ADDR_W = `PBS_ADDR_W,
   parameter LANES = `PBS_LANES,
   parameter LANE_W = `PBS_LANE_W,
   parameter WAKE_CYCLES = `PBS_WAKE_CYCLES
) (
   input wire clock,
   input wire sys_rst,
   input wire clk_en,
   input wire [ADDR_W-1:0] address,
   input wire processor_address_strobe_n,
   input wire controller_address_strobe_n,
   input wire burst_advance_n,
   input wire global_write_n,
   input wire byte_write_enable_n,
   input wire [LANES-1:0] byte_lane_write_n,
   input wire primary_select_n,
   input wire secondary_select,
   input wire tertiary_select_n,
   input wire output_drive_enable_n,
   input wire burst_order_select,
   input wire power_down_request,
   input wire [LANES*LANE_W-1:0] data_in,
   output reg [LANES*LANE_W-1:0] data_out,
   output wire data_oe_n,
   output reg power_down_active,
   output reg core_ready
);

   localparam DATA_W = LANES * LANE_W;
   localparam [`PBS_WAKE_W-1:0] WAKE_LOAD = WAKE_CYCLES[`PBS_WAKE_W-1:0];

   // state machine of the access cycle
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_BURST = 2'b01;
   localparam [1:0] ST_SLEEP = 2'b10;
   localparam [1:0] ST_WAKE = 2'b11;

   // lane decode shared by the controller-start and burst-continue paths
   function [LANES-1:0] write_lanes;
      input gw_n;
      input bw_n;
      input [LANES-1:0] we_n;
      begin
         if (!gw_n)
         begin
            write_lanes = `PBS_LANES_ALL;
         end
         else if (!bw_n)
         begin
            write_lanes = ~we_n;
         end
         else
         begin
            write_lanes = `PBS_LANES_NONE;
         end
      end
   endfunction

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg zz_meta_q;
   reg zz_sync_q;
   reg [`PBS_WAKE_W-1:0] wake_q;
   reg [`PBS_WAKE_W-1:0] wake_d;
   reg read_beat_q;
   reg read_stage_q;
   reg drive_q;
   reg [LANES-1:0] wr_lanes_q;
   reg [DATA_W-1:0] wr_data_q;

   reg burst_load;
   reg burst_step;
   reg read_beat_d;
   reg [LANES-1:0] wr_lanes_d;

   wire [ADDR_W-1:0] cur_addr;
   wire [DATA_W-1:0] rd_data;
   wire selected;
   wire proc_start;
   wire ctrl_start;
   wire [LANES-1:0] lanes_now;
   wire write_now;

   assign selected = !primary_select_n && secondary_select && !tertiary_select_n;
   // primary select high makes the processor strobe invisible
   assign proc_start = !processor_address_strobe_n && !primary_select_n;
   // controller strobe counts with the processor strobe high, or with that
   // strobe blocked by the primary select
   assign ctrl_start = !controller_address_strobe_n && !proc_start;
   assign lanes_now = write_lanes(global_write_n, byte_write_enable_n, byte_lane_write_n);
   assign write_now = |lanes_now;

   // cycle decode; everything here is taken at the rising edge
   always @*
   begin
      state_d = state_q;
      wake_d = wake_q;
      burst_load = 1'b0;
      burst_step = 1'b0;
      read_beat_d = 1'b0;
      wr_lanes_d = `PBS_LANES_NONE;
      case (state_q)
         ST_SLEEP:
         begin
            // nothing moves while asleep; array and registers hold
            if (!zz_sync_q)
            begin
               state_d = ST_WAKE;
               wake_d = WAKE_LOAD - `PBS_WAKE_ONE;
            end
         end
         ST_WAKE:
         begin
            if (zz_sync_q)
            begin
               state_d = ST_SLEEP;
            end
            else if (wake_q == `PBS_WAKE_ZERO)
            begin
               state_d = ST_IDLE;
            end
            else
            begin
               wake_d = wake_q - `PBS_WAKE_ONE;
            end
         end
         ST_IDLE, ST_BURST:
         begin
            if (zz_sync_q)
            begin
               state_d = ST_SLEEP;
            end
            else if (proc_start)
            begin
               // lane writes and advance are not looked at on this edge
               if (selected)
               begin
                  burst_load = 1'b1;
                  read_beat_d = 1'b1;
                  state_d = ST_BURST;
               end
               else
               begin
                  state_d = ST_IDLE;
               end
            end
            else if (ctrl_start)
            begin
               if (selected)
               begin
                  burst_load = 1'b1;
                  state_d = ST_BURST;
                  // first beat may already be a write at the external address
                  wr_lanes_d = lanes_now;
                  read_beat_d = !write_now;
               end
               else
               begin
                  state_d = ST_IDLE;
               end
            end
            else if (state_q == ST_BURST)
            begin
               // written one edge later, at the position this edge steps to
               wr_lanes_d = lanes_now;
               read_beat_d = !write_now;
               // suspend when advance is high, in either direction
               burst_step = !burst_advance_n;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // power-down is asynchronous to this clock; two flops before use
   always @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         zz_meta_q <= 1'b0;
         zz_sync_q <= 1'b0;
      end
      else if (clk_en)
      begin
         zz_meta_q <= power_down_request;
         zz_sync_q <= zz_meta_q;
      end
   end

   always @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= ST_IDLE;
         wake_q <= `PBS_WAKE_ZERO;
         read_beat_q <= 1'b0;
         read_stage_q <= 1'b0;
         drive_q <= 1'b0;
         wr_lanes_q <= `PBS_LANES_NONE;
         wr_data_q <= `PBS_DATA_ZERO;
         data_out <= `PBS_DATA_ZERO;
         power_down_active <= 1'b0;
         core_ready <= 1'b0;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         wake_q <= wake_d;
         read_beat_q <= read_beat_d;
         read_stage_q <= read_beat_q;
         wr_lanes_q <= wr_lanes_d;
         if (|wr_lanes_d)
         begin
            wr_data_q <= data_in;
         end
         // second pipeline stage: data-out register to output buffer
         if (read_stage_q)
         begin
            data_out <= rd_data;
         end
         // a write beat pulls the drivers off at once
         if (|wr_lanes_d)
         begin
            drive_q <= 1'b0;
         end
         else
         begin
            drive_q <= read_stage_q;
         end
         power_down_active <= (state_d == ST_SLEEP);
         core_ready <= (state_d == ST_IDLE) || (state_d == ST_BURST);
      end
   end

   // drive enable and power-down act without the clock; deliberate
   // combinational path so the bus frees within the pin delay
   assign data_oe_n = !(drive_q && !output_drive_enable_n && !power_down_request);

   pbs_burst #(
      .ADDR_W(ADDR_W),
      .BURST_W(`PBS_BURST_W)
   ) u_burst (
      .clock(clock),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .load(burst_load),
      .advance(burst_step),
      .ext_addr(address),
      .order(burst_order_select),
      .cur_addr(cur_addr)
   );

   // first pipeline stage lives in the array's registered read port
   // writes land one edge after capture, at the address that edge left, so a
   // stepping write beat goes to the next position the order
   // select must stay put while a write is in flight
   pbs_mem #(
      .ADDR_W(ADDR_W),
      .LANES(LANES),
      .LANE_W(LANE_W)
   ) u_mem (
      .clock(clock),
      .clk_en(clk_en),
      .rd_addr(cur_addr),
      .rd_data_q(rd_data),
      .wr_lanes(wr_lanes_q),
      .wr_addr(cur_addr),
      .wr_data(wr_data_q)
   );

endmodule // pbs_core

// ==== verif/pbs_core_props.sv ====
// pbs_core_props.sv: pin-level timing properties of the burst memory core.
// assumes: bound to pbs_core; one clock, asynchronous reset active high.
`timescale 1ns/10ps
module pbs_core_props #(
   parameter LANES = 4
) (
   input wire clock,
   input wire sys_rst,
   input wire clk_en,
   input wire processor_address_strobe_n,
   input wire controller_address_strobe_n,
   input wire global_write_n,
   input wire byte_write_enable_n,
   input wire [LANES-1:0] byte_lane_write_n,
   input wire primary_select_n,
   input wire secondary_select,
   input wire tertiary_select_n,
   input wire output_drive_enable_n,
   input wire power_down_request,
   input wire data_oe_n,
   input wire power_down_active,
   input wire core_ready
);
   wire sel_ok = !primary_select_n && secondary_select && !tertiary_select_n;
   wire live = clk_en && core_ready;
   wire rd_go = live && !processor_address_strobe_n && sel_ok;
   wire wr_go = live && processor_address_strobe_n && !controller_address_strobe_n && sel_ok
      && (!global_write_n || (!byte_write_enable_n && !(&byte_lane_write_n)));
   // quiet edge: no start and nothing written, so a burst only reads
   wire quiet = live && processor_address_strobe_n && controller_address_strobe_n && global_write_n
      && (byte_write_enable_n || (&byte_lane_write_n));
   wire desel = live && !processor_address_strobe_n && !primary_select_n && !sel_ok;
   default clocking dc @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_oe_follow: assert property (output_drive_enable_n |-> data_oe_n)
      else $error("drivers on while drive enable is high");
   a_sleep_hiz: assert property (power_down_request |-> data_oe_n)
      else $error("drivers on while power-down is requested");
   a_read_lat: assert property (rd_go ##1 quiet [*2] |=> (!data_oe_n || output_drive_enable_n))
      else $error("read data not driven two edges after start");
   a_write_off: assert property (wr_go |=> data_oe_n)
      else $error("drivers still on after a write edge");
   a_desel_idle: assert property (desel ##1 quiet [*2] |=> data_oe_n)
      else $error("deselected start still drives data");
   a_sleep_enter: assert property ((power_down_request && clk_en) [*6] |-> power_down_active)
      else $error("no low-power state after request");
   a_sleep_ready: assert property (power_down_active |-> !core_ready)
      else $error("ready while asleep");
   a_wake_gap: assert property ($fell(power_down_request) && power_down_active
      |-> !core_ready [*5] ##1 core_ready)
      else $error("wake-up interval wrong");
   c_read: cover property (rd_go ##1 quiet);
   c_write: cover property (wr_go);
   c_wake: cover property ($fell(power_down_request) && power_down_active);
endmodule // pbs_core_props

bind pbs_core pbs_core_props #(.LANES(LANES)) u_props (.clock, .sys_rst, .clk_en, .processor_address_strobe_n,
   .controller_address_strobe_n, .global_write_n, .byte_write_enable_n, .byte_lane_write_n, .primary_select_n,
   .secondary_select, .tertiary_select_n, .output_drive_enable_n, .power_down_request, .data_oe_n,
   .power_down_active, .core_ready);

// ==== verif/pbs_host.sv ====
// pbs_host.sv: processor-side model that drives the memory pins.
// assumes: the bench calls drv, which changes pins on the falling clock; the bench also sets a few pins directly, up to 4 ns after it.
`timescale 1ns/10ps
module pbs_host (
   input wire clock,
   output reg [15:0] address,
   output reg processor_address_strobe_n,
   output reg controller_address_strobe_n,
   output reg burst_advance_n,
   output reg global_write_n,
   output reg byte_write_enable_n,
   output reg [3:0] byte_lane_write_n,
   output reg primary_select_n,
   output reg secondary_select,
   output reg tertiary_select_n,
   output reg output_drive_enable_n,
   output reg burst_order_select,
   output reg power_down_request,
   output reg [31:0] data_in
);
   initial
   begin
      {processor_address_strobe_n, controller_address_strobe_n, burst_advance_n, global_write_n} = 4'hF;
      {byte_write_enable_n, primary_select_n, secondary_select, tertiary_select_n} = 4'hA;
      {output_drive_enable_n, burst_order_select, power_down_request} = 3'h0;
      byte_lane_write_n = 4'hF;
      address = 16'h0000;
      data_in = 32'h0000_0000;
   end
   // st = {processor strobe, controller strobe}
   task drv(input [1:0] st, input burst_advance, input gw, input bw, input [3:0] ln, input [31:0] d, input [15:0] a);
      begin
         @(negedge clock);
         {processor_address_strobe_n, controller_address_strobe_n} = st;
         {burst_advance_n, global_write_n, byte_write_enable_n} = {burst_advance, gw, bw};
         byte_lane_write_n = ln;
         address = a;
         output_drive_enable_n = ~gw | (~bw & ~(&ln));
         // released bus flips so a stale value never passes
         data_in = output_drive_enable_n ? d : ~data_in;
      end
   endtask
endmodule // pbs_host

// ==== verif/pbs_core_tb.sv ====
// pbs_core_tb.sv: self-checking bench for the burst memory core.
// assumes: pbs_host drives the pins; words 0x0010..0x0013 are the test area.
`timescale 1ns/10ps
module pbs_core_tb;
   reg clock = 1'h0;
   reg sys_rst = 1'h1;
   reg clk_en = 1'h1;
   wire [15:0] address;
   wire processor_address_strobe_n, controller_address_strobe_n, burst_advance_n, global_write_n;
   wire byte_write_enable_n, primary_select_n, secondary_select, tertiary_select_n;
   wire output_drive_enable_n, burst_order_select, power_down_request;
   wire [3:0] byte_lane_write_n;
   wire [31:0] data_in, data_out;
   wire data_oe_n, power_down_active, core_ready;
   integer n_fail = 0;
   integer total_checks = 0;
   integer k;
   reg [31:0] mem [0:3];
   reg [7:0] seq = 8'h30;
   reg [3:0] bad [0:2];
   always #25 clock = ~clock;
   pbs_host u_host (.clock, .address, .processor_address_strobe_n, .controller_address_strobe_n,
      .burst_advance_n, .global_write_n, .byte_write_enable_n, .byte_lane_write_n, .primary_select_n,
      .secondary_select, .tertiary_select_n, .output_drive_enable_n, .burst_order_select,
      .power_down_request, .data_in);
   pbs_core u_dut (.clock, .sys_rst, .clk_en, .address, .processor_address_strobe_n,
      .controller_address_strobe_n, .burst_advance_n, .global_write_n, .byte_write_enable_n,
      .byte_lane_write_n, .primary_select_n, .secondary_select, .tertiary_select_n, .output_drive_enable_n,
      .burst_order_select, .power_down_request, .data_in, .data_out, .data_oe_n, .power_down_active,
      .core_ready);
   task chk(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp)
         begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chkb(input got, input exp);
      begin
         chk({31'h0, got}, {31'h0, exp});
      end
   endtask
   function [1:0] nx(input [1:0] s, input [1:0] n, input o);
      nx = o ? s ^ n : s + n;
   endfunction
   task wrb(input [15:0] a, input gw, input [3:0] ln, input integer nb);
      integer i;
      reg [31:0] d, m;
      reg [1:0] w;
      begin
         m = {{8{~ln[3]}}, {8{~ln[2]}}, {8{~ln[1]}}, {8{~ln[0]}}};
         for (i = 0; i < nb; i = i + 1)
         begin
            seq = seq + 8'h01;
            d = {seq, ~seq, a};
            u_host.drv(i == 0 ? 2'h2 : 2'h3, 1'h0, gw, 1'h0, ln, d, a);
            w = nx(a[1:0], i[1:0], u_host.burst_order_select);
            mem[w] = gw ? (mem[w] & ~m) | (d & m) : d;
         end
         u_host.drv(2'h3, 1'h1, 1'h1, 1'h1, 4'hF, 32'h0, a);
      end
   endtask
   task rdb(input [15:0] a, input [3:0] burst_advance, input [3:0] ln0);
      integer i;
      reg [1:0] c [0:3];
      begin
         c[0] = 2'h0;
         // advance and lanes held low on the start edge must be ignored
         u_host.drv(2'h1, 1'h0, 1'h1, 1'h0, ln0, 32'h0, a);
         for (i = 0; i < 6; i = i + 1)
         begin
            u_host.drv(2'h3, i < 4 ? burst_advance[i] : 1'h1, 1'h1, 1'h1, 4'hF, 32'h0, a);
            if (i < 3)
               c[i + 1] = c[i] + {1'h0, ~burst_advance[i]};
            if (i == 2)
               chkb(data_oe_n, 1'h0);
            if (i >= 2)
               chk(data_out, mem[nx(a[1:0], c[i - 2], u_host.burst_order_select)]);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial
   begin
      #100000;
      n_fail = n_fail + 1;
      report_and_stop;
   end
   initial
   begin
      // bit 3: expected drive-off; primary high first, so the burst runs on
      bad[0] = 4'h6;
      bad[1] = 4'h8;
      bad[2] = 4'hB;
      repeat (6) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'h0;
      wrb(16'h0012, 1'h0, 4'hF, 4);
      wrb(16'h0011, 1'h1, 4'hA, 2);
      @(negedge clock);
      u_host.burst_order_select = 1'h1;
      rdb(16'h0013, 4'h0, 4'h0);
      wrb(16'h0011, 1'h1, 4'h0, 3);
      @(negedge clock);
      u_host.burst_order_select = 1'h0;
      rdb(16'h0010, 4'h2, 4'hF);
      u_host.output_drive_enable_n = 1'h1;
      #1;
      chkb(data_oe_n, 1'h1);
      u_host.output_drive_enable_n = 1'h0;
      #1;
      chkb(data_oe_n, 1'h0);
      u_host.power_down_request = 1'h1;
      #1;
      chkb(data_oe_n, 1'h1);
      u_host.power_down_request = 1'h0;
      #1;
      for (k = 0; k < 3; k = k + 1)
      begin
         {u_host.primary_select_n, u_host.secondary_select, u_host.tertiary_select_n} = bad[k][2:0];
         u_host.drv(2'h1, 1'h1, 1'h1, 1'h1, 4'hF, 32'h0, 16'h0010);
         repeat (4) u_host.drv(2'h3, 1'h0, 1'h1, 1'h1, 4'hF, 32'h0, 16'h0010);
         chkb(data_oe_n, bad[k][3]);
      end
      {u_host.primary_select_n, u_host.secondary_select, u_host.tertiary_select_n} = 3'h2;
      u_host.power_down_request = 1'h1;
      #1;
      chkb(data_oe_n, 1'h1);
      repeat (8) @(negedge clock);
      chkb(power_down_active, 1'h1);
      u_host.power_down_request = 1'h0;
      repeat (2) @(negedge clock);
      chkb(core_ready, 1'h0);
      k = 0;
      while (core_ready !== 1'h1 && k < 12)
      begin
         @(negedge clock);
         k = k + 1;
      end
      chkb(core_ready, 1'h1);
      chk(k, 32'h3);
      rdb(16'h0012, 4'h0, 4'hF);
      // frozen clock enable: request ignored, read data held
      clk_en = 1'h0;
      u_host.power_down_request = 1'h1;
      repeat (8) @(negedge clock);
      chkb(power_down_active, 1'h0);
      chk(data_out, mem[1]);
      u_host.power_down_request = 1'h0;
      clk_en = 1'h1;
      report_and_stop;
   end
endmodule // pbs_core_tb
